// >>> src/sdd_consts.svh
/*
 Register indices, field positions, reset values and sizes of the socket DMA slave.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

// Register indices; byte address is four times the index
`define SDD_IDX_ADDR 6'h00
`define SDD_IDX_COUNT 6'h04
`define SDD_IDX_STATUS 6'h08
`define SDD_IDX_SWREQ 6'h09
`define SDD_IDX_CTRL 6'h0A
`define SDD_IDX_MODE 6'h0B
`define SDD_IDX_MCLR 6'h0D
`define SDD_IDX_MASK 6'h0F

// Field positions
`define SDD_MODE_SEL_HI 7
`define SDD_MODE_SEL_LO 6
`define SDD_MODE_DIR_BIT 5
`define SDD_MODE_AUTO_BIT 4
`define SDD_MODE_XFER_HI 3
`define SDD_MODE_XFER_LO 2
`define SDD_CMD_DIS_BIT 2
`define SDD_CTRL_WIDE_BIT 0
`define SDD_MASK_BIT 0

// Reset values and the terminal count set value
`define SDD_MODE_RST 6'h00
`define SDD_MASK_RST 1'b0
`define SDD_TC_SET 4'hF

// Sizes
`define SDD_DATA_W 16
`define SDD_ADDR_W 16
`define SDD_FIFO_DEPTH 32

`endif

// >>> src/sdd_pkg.sv
/*
 Types of the socket DMA slave: transfer modes and transfer directions.
 Assumes nothing of its surroundings.
*/
package sdd_pkg;
	typedef enum logic [1:0] {
		SDD_DEMAND = 2'b00,
		SDD_SINGLE = 2'b01,
		SDD_BLOCK = 2'b10,
		SDD_MODE_RSV = 2'b11
	} sdd_mode_t;

	typedef enum logic [1:0] {
		SDD_XFER_NONE = 2'b00,
		SDD_XFER_WRITE = 2'b01,
		SDD_XFER_READ = 2'b10,
		SDD_XFER_RSV = 2'b11
	} sdd_xfer_t;
endpackage

// >>> src/sdd_fifo_if.sv
/*
 Push and pop channels between the socket DMA control and its data FIFO.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface sdd_fifo_if #(parameter int WIDTH = 32);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
	modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// >>> src/sdd_sync.sv
/*
 Two-stage synchroniser for pin levels.
 Assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/100ps
`default_nettype none
module sdd_sync #(parameter int WIDTH = 2) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_sync <= '0;
		end else if (i_clk_en) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // sdd_sync
`default_nettype wire

// >>> src/sdd_fifo.sv
/*
 Flip-flop FIFO with valid and ready on both sides and a flush.
 Assumes DEPTH is a power of two, at least two.
*/
`timescale 1ns/100ps
`default_nettype none
module sdd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_flush,
	sdd_fifo_if.fifo bus
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("sdd_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	wire push = bus.push_valid & bus.push_ready;
	wire pop = bus.pop_valid & bus.pop_ready;

	assign bus.push_ready = (cnt_q != (PW+1)'(DEPTH));
	assign bus.pop_valid = (cnt_q != '0);
	assign bus.pop_data = mem_q[rd_q];

	always_ff @(posedge i_clock) begin
		if (i_clk_en && push) begin
			mem_q[wr_q] <= bus.push_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (i_clk_en) begin
			if (i_flush) begin
				wr_q <= '0;
				rd_q <= '0;
				cnt_q <= '0;
			end else begin
				wr_q <= wr_q + PW'(push);
				rd_q <= rd_q + PW'(pop);
				cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
			end
		end
	end
endmodule // sdd_fifo
`default_nettype wire

// >>> src/sdd_top.sv
/*
 Socket distributed DMA slave channel: status, software request, mode, master clear,
 mask, address and count registers on classic Wishbone, a transfer engine and a data FIFO.
 Assumes a card request pin and a card present pin asynchronous to i_clock, and a data
 source and sink on i_clock.
*/
// Contract
// - Upper status bits follow card request
// - Request status ignores the mask bit
// - Terminal count sets all four lower bits
// - Status read or channel reset clears them
// - Any software request write requests transfer
// - Mode field: demand, single, block, reserved
// - Address steps up or down per transfer
// - Mode bit enables auto reload
// - Transfer type: none, write, read, reserved
// - Two lowest mode bits read zero
// - Master clear resets every channel register; a card removal in the same cycle still sets the mask bit
// - Mask register holds only bit zero
// - Card removal sets the mask bit
// - Masked card requests are ignored
// - Count drops one or two per transfer
`timescale 1ns/100ps
`default_nettype none
`include "sdd_consts.svh"
module sdd_top import sdd_pkg::*; #(
	parameter int DATA_W = `SDD_DATA_W,
	parameter int ADDR_W = `SDD_ADDR_W,
	parameter int FIFO_DEPTH = `SDD_FIFO_DEPTH
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire logic i_card_dreq,
	input wire logic i_card_present,
	input wire logic i_src_valid,
	input wire logic [DATA_W-1:0] i_src_data,
	output logic o_src_ready,
	output logic o_dst_valid,
	output logic [DATA_W-1:0] o_dst_data,
	output logic [ADDR_W-1:0] o_dst_addr,
	output logic o_dst_to_mem,
	input wire logic i_dst_ready
);
	localparam int FW = ADDR_W + DATA_W;

	if (ADDR_W < 2 || ADDR_W > 16 || DATA_W < 1 || DATA_W > 32) begin : g_bad_width
		$error("sdd_top: ADDR_W must be 2..16 and DATA_W 1..32");
	end

	// Byte-lane merge of a 16-bit register
	function automatic logic [ADDR_W-1:0] merge16(input logic [ADDR_W-1:0] old,
			input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] v;
		v = 16'(old);
		if (sel[0]) v[7:0] = dat[7:0];
		if (sel[1]) v[15:8] = dat[15:8];
		return ADDR_W'(v);
	endfunction

	// Bus decode
	logic ack_q;
	wire [5:0] idx = i_wb_adr[7:2];
	wire wb_req = i_wb_cyc & i_wb_stb & ~ack_q;
	wire wb_wr = wb_req & i_wb_we;
	wire wb_rd = wb_req & ~i_wb_we;
	wire hit_addr = (idx == `SDD_IDX_ADDR);
	wire hit_count = (idx == `SDD_IDX_COUNT);
	wire hit_stat = (idx == `SDD_IDX_STATUS);
	wire hit_swreq = (idx == `SDD_IDX_SWREQ);
	wire hit_ctrl = (idx == `SDD_IDX_CTRL);
	wire hit_mode = (idx == `SDD_IDX_MODE);
	wire hit_mclr = (idx == `SDD_IDX_MCLR);
	wire hit_mask = (idx == `SDD_IDX_MASK);
	wire lane0 = i_wb_sel[0];
	wire clr = wb_wr & hit_mclr;
	wire stat_rd = wb_rd & hit_stat;
	wire sw_wr = wb_wr & hit_swreq;

	// Channel registers
	logic [ADDR_W-1:0] base_addr_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] base_count_q;
	logic [ADDR_W-1:0] count_q;
	logic [7:2] mode_q;
	logic dis_q;
	logic wide_q;
	logic mask_q;
	logic [3:0] tc_flags_q;
	logic sw_q;
	logic blk_q;
	logic armed_q;
	logic done_q;
	logic present_prev_q;
	logic src_ready_q;
	logic dst_valid_q;
	logic [DATA_W-1:0] dst_data_q;
	logic [ADDR_W-1:0] dst_addr_q;
	logic dst_to_mem_q;
	logic [31:0] rdat_q;

	// Pins
	logic [1:0] pin_s;
	sdd_sync #(.WIDTH(2)) u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_async({i_card_present, i_card_dreq}),
		.o_sync(pin_s)
	);
	wire dreq_s = pin_s[0];
	wire present_s = pin_s[1];
	wire removal = present_prev_q & ~present_s;

	// Mode fields
	wire sdd_mode_t mode_sel = sdd_mode_t'(mode_q[`SDD_MODE_SEL_HI:`SDD_MODE_SEL_LO]);
	wire addr_dec = mode_q[`SDD_MODE_DIR_BIT];
	wire auto_en = mode_q[`SDD_MODE_AUTO_BIT];
	wire sdd_xfer_t xfer = sdd_xfer_t'(mode_q[`SDD_MODE_XFER_HI:`SDD_MODE_XFER_LO]);
	wire xfer_ok = (xfer == SDD_XFER_WRITE) | (xfer == SDD_XFER_READ);

	// Transfer engine
	wire card_req = dreq_s & ~mask_q;
	wire any_req = card_req | sw_q;
	logic want;
	always_comb begin
		case (mode_sel)
			SDD_DEMAND: want = any_req;
			SDD_SINGLE: want = any_req & armed_q;
			SDD_BLOCK: want = any_req | blk_q;
			default: want = 1'b0;
		endcase
	end

	sdd_fifo_if #(.WIDTH(FW)) fif ();
	wire take = i_src_valid & src_ready_q;
	wire [ADDR_W-1:0] step = wide_q ? ADDR_W'(2) : ADDR_W'(1);
	wire tc = take & (count_q <= step);
	wire reload = tc & auto_en;
	wire [ADDR_W-1:0] addr_next = addr_dec ? addr_q - ADDR_W'(1) : addr_q + ADDR_W'(1);
	wire can_run = want & xfer_ok & ~dis_q & ~done_q & fif.push_ready;
	wire pop = fif.pop_valid & (~dst_valid_q | i_dst_ready);

	assign fif.push_valid = take & i_clk_en;
	assign fif.push_data = {addr_q, i_src_data};
	assign fif.pop_ready = pop & i_clk_en;

	sdd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_flush(clr),
		.bus(fif)
	);

	// Read data
	wire [31:0] stat_word = {24'h000000, {4{dreq_s}}, tc_flags_q};
	wire [31:0] mode_word = {24'h000000, mode_q, 2'b00};
	wire [31:0] rd_mux = hit_addr ? 32'(addr_q) :
		hit_count ? 32'(count_q) :
		hit_stat ? stat_word :
		hit_ctrl ? {31'h00000000, wide_q} :
		hit_mode ? mode_word :
		hit_mask ? {31'h00000000, mask_q} : 32'h00000000;

	// Bus answer
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else if (i_clk_en) begin
			ack_q <= wb_req;
			if (wb_rd) rdat_q <= rd_mux;
		end
	end

	// Mode, control and command
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= `SDD_MODE_RST;
			dis_q <= 1'b0;
			wide_q <= 1'b0;
		end else if (i_clk_en) begin
			if (clr) begin
				mode_q <= `SDD_MODE_RST;
				dis_q <= 1'b0;
				wide_q <= 1'b0;
			end else begin
				if (wb_wr && hit_mode && lane0) mode_q <= i_wb_dat[7:2];
				if (wb_wr && hit_stat && lane0) dis_q <= i_wb_dat[`SDD_CMD_DIS_BIT];
				if (wb_wr && hit_ctrl && lane0) wide_q <= i_wb_dat[`SDD_CTRL_WIDE_BIT];
			end
		end
	end

	// Mask and card presence
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_q <= `SDD_MASK_RST;
			present_prev_q <= 1'b0;
		end else if (i_clk_en) begin
			present_prev_q <= present_s;
			if (removal) mask_q <= 1'b1;
			else if (clr) mask_q <= `SDD_MASK_RST;
			else if (wb_wr && hit_mask && lane0) mask_q <= i_wb_dat[`SDD_MASK_BIT];
		end
	end

	// Terminal count flags, set wins over read
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tc_flags_q <= 4'h0;
		end else if (i_clk_en) begin
			if (clr) tc_flags_q <= 4'h0;
			else if (tc) tc_flags_q <= `SDD_TC_SET;
			else if (stat_rd) tc_flags_q <= 4'h0;
		end
	end

	// Address and count
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			base_addr_q <= '0;
			addr_q <= '0;
			base_count_q <= '0;
			count_q <= '0;
		end else if (i_clk_en) begin
			if (clr) begin
				base_addr_q <= '0;
				addr_q <= '0;
				base_count_q <= '0;
				count_q <= '0;
			end else if (wb_wr && hit_addr) begin
				base_addr_q <= merge16(base_addr_q, i_wb_dat, i_wb_sel);
				addr_q <= merge16(addr_q, i_wb_dat, i_wb_sel);
			end else if (wb_wr && hit_count) begin
				base_count_q <= merge16(base_count_q, i_wb_dat, i_wb_sel);
				count_q <= merge16(count_q, i_wb_dat, i_wb_sel);
			end else if (reload) begin
				addr_q <= base_addr_q;
				count_q <= base_count_q;
			end else if (take) begin
				addr_q <= addr_next;
				count_q <= count_q - step;
			end
		end
	end

	// Request state
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sw_q <= 1'b0;
			blk_q <= 1'b0;
			armed_q <= 1'b1;
			done_q <= 1'b0;
			src_ready_q <= 1'b0;
		end else if (i_clk_en) begin
			if (clr) begin
				sw_q <= 1'b0;
				blk_q <= 1'b0;
				armed_q <= 1'b1;
				done_q <= 1'b0;
				src_ready_q <= 1'b0;
			end else begin
				if (sw_wr) sw_q <= 1'b1;
				else if (tc) sw_q <= 1'b0;
				if (tc) blk_q <= 1'b0;
				else if (take && mode_sel == SDD_BLOCK) blk_q <= 1'b1;
				if (take && mode_sel == SDD_SINGLE) armed_q <= 1'b0;
				else if (!any_req) armed_q <= 1'b1;
				if (wb_wr && (hit_count || hit_addr)) done_q <= 1'b0;
				else if (tc && !auto_en) done_q <= 1'b1;
				// Ready drops for the cycle after each take so state settles
				src_ready_q <= can_run & ~take;
			end
		end
	end

	// Output stage toward the sink
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dst_valid_q <= 1'b0;
			dst_data_q <= '0;
			dst_addr_q <= '0;
			dst_to_mem_q <= 1'b0;
		end else if (i_clk_en) begin
			dst_to_mem_q <= (xfer == SDD_XFER_WRITE);
			if (clr) begin
				dst_valid_q <= 1'b0;
			end else if (pop) begin
				dst_valid_q <= 1'b1;
				dst_data_q <= fif.pop_data[DATA_W-1:0];
				dst_addr_q <= fif.pop_data[FW-1:DATA_W];
			end else if (i_dst_ready) begin
				dst_valid_q <= 1'b0;
			end
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_src_ready = src_ready_q;
	assign o_dst_valid = dst_valid_q;
	assign o_dst_data = dst_data_q;
	assign o_dst_addr = dst_addr_q;
	assign o_dst_to_mem = dst_to_mem_q;

	// Checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// Removal in the clear cycle still masks, so it is left out
	sequence s_mclr_write;
		i_clk_en && clr && !removal;
	endsequence

	sequence s_all_cleared;
		mode_q == 6'h00 && !mask_q && tc_flags_q == 4'h0 && count_q == '0 &&
			addr_q == '0 && !sw_q && !src_ready_q;
	endsequence

	a_req_status_follow: assert property (i_clk_en && stat_rd |=> o_wb_ack &&
		o_wb_dat[7:4] == {4{$past(dreq_s)}}) else $error("request status wrong");
	a_req_ignores_mask: assert property (i_clk_en && stat_rd && mask_q && dreq_s |=>
		o_wb_dat[7:4] == 4'hF) else $error("mask hid request status");
	a_tc_sets_flags: assert property (i_clk_en && tc && !clr |=> tc_flags_q == 4'hF)
		else $error("terminal count flags not set");
	a_tc_read_clears: assert property (i_clk_en && stat_rd && !tc |=> tc_flags_q == 4'h0)
		else $error("status read left count flags");
	a_sw_req_sets: assert property (i_clk_en && sw_wr && !clr |=> sw_q)
		else $error("software request lost");
	a_mode_low_zero: assert property (i_clk_en && wb_rd && hit_mode |=> o_wb_dat[1:0] == 2'b00)
		else $error("mode low bits not zero");
	a_master_clear_all: assert property (s_mclr_write |=> s_all_cleared)
		else $error("master clear incomplete");
	a_removal_masks: assert property (i_clk_en && removal |=> mask_q && o_src_ready == 1'b0 ||
		mask_q) else $error("removal did not mask");
	a_mask_blocks_card: assert property (i_clk_en && mask_q && !sw_q && !blk_q &&
		mode_sel != SDD_BLOCK |=> !o_src_ready) else $error("masked request served");
	a_addr_step: assert property (i_clk_en && take && !reload && !wb_wr |=>
		addr_q == ($past(addr_dec) ? $past(addr_q) - ADDR_W'(1) : $past(addr_q) + ADDR_W'(1)))
		else $error("address step wrong");
	a_count_step: assert property (i_clk_en && take && !reload && !wb_wr |=>
		$past(count_q) - count_q == ($past(wide_q) ? ADDR_W'(2) : ADDR_W'(1)))
		else $error("count step wrong");
	a_auto_reload: assert property (i_clk_en && reload && !wb_wr |=>
		addr_q == $past(base_addr_q) && count_q == $past(base_count_q) && !done_q)
		else $error("auto reload failed");
	a_push_room: assert property (fif.push_valid |-> fif.push_ready)
		else $error("push into full fifo");
endmodule // sdd_top
`default_nettype wire

// >>> sim/sdd_card_model.sv
/*
 Card model: request and presence pins and a counting data source.
 Assumes the bench commands request, insertion and source pacing.
*/
`timescale 1ns/100ps
`default_nettype none
module sdd_card_model (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic i_insert,
	input wire logic i_slow,
	input wire logic i_src_ready,
	output logic o_dreq,
	output logic o_present,
	output logic o_src_valid,
	output logic [15:0] o_src_data
);
	logic [15:0] cnt_q;
	logic ph_q;
	assign o_present = i_insert;
	assign o_dreq = i_req & i_insert;
	assign o_src_valid = i_insert & ~(i_slow & ph_q);
	// Idle data shows the inverse, never a stale beat
	assign o_src_data = o_src_valid ? cnt_q : ~cnt_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 16'hA500;
			ph_q <= 1'b0;
		end else begin
			ph_q <= ~ph_q;
			if (o_src_valid & i_src_ready)
				cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule // sdd_card_model
`default_nettype wire

// >>> sim/sdd_top_tb_top.sv
/*
 Self-checking bench of the socket DMA slave: Wishbone master, card model, random sink.
 Assumes the design's register map and one 125 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sdd_top_tb_top;
	logic clock, rst_n, cyc, stb, we, ack, dreq, present, req, insert, slow;
	logic src_valid, src_ready, dst_valid, dst_ready, to_mem;
	logic [7:0] adr, v;
	logic [3:0] sel;
	logic [31:0] dat, rdat, r;
	logic [15:0] src_data, dst_data, dst_addr;
	logic [4:0] i;
	logic [31:0] rd_q[$], mk_q[$], dq[$];
	int err_total, check_count, k, tick;
	sdd_top uut (.i_clock(clock), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
		.o_wb_ack(ack), .o_wb_dat(rdat), .i_card_dreq(dreq), .i_card_present(present),
		.i_src_valid(src_valid), .i_src_data(src_data), .o_src_ready(src_ready),
		.o_dst_valid(dst_valid), .o_dst_data(dst_data), .o_dst_addr(dst_addr),
		.o_dst_to_mem(to_mem), .i_dst_ready(dst_ready));
	sdd_card_model card (.i_clock(clock), .i_rst_n(rst_n), .i_req(req), .i_insert(insert),
		.i_slow(slow), .i_src_ready(src_ready), .o_dreq(dreq), .o_present(present),
		.o_src_valid(src_valid), .o_src_data(src_data));
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Write when w; otherwise read expecting e under mask m
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rd_q.push_back(w ? 32'h0 : (e & m));
		mk_q.push_back(w ? 32'h0 : m);
		@(posedge clock);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h3, w ? e : 32'h0};
		// Ack sampled at a rising edge; only the bench timeout ends a hang
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic beats(input logic tm, input logic [15:0] a0, input int n, input logic dn);
		logic [15:0] a;
		for (int j = 0; j < n; j++) begin
			a = dn ? a0 - 16'(j) : a0 + 16'(j);
			dq.push_back({tm, a[14:0], 16'hA500 + k[15:0]});
			k++;
		end
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (dq.size() > 0 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		repeat (20) @(posedge clock);
		cmp("beats_left", 32'h0, 32'(dq.size()));
	endtask
	always @(negedge clock) begin
		if (ack === 1'b1) begin
			if (rd_q.size() > 0)
				cmp("wb_dat", rd_q.pop_front(), rdat & mk_q.pop_front());
			else
				cmp("wb_ack_extra", 32'h0, 32'h1);
		end
		if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
			if (dq.size() > 0)
				cmp("dst_beat", dq.pop_front(), {to_mem, dst_addr[14:0], dst_data});
			else
				cmp("dst_extra", 32'h0, 32'h1);
		end
	end
	always @(posedge clock) begin
		tick++;
		if (tick == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		{rst_n, cyc, stb, we, adr, sel, dat, req, slow, dst_ready} = '0;
		insert = 1'b1;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		r = $urandom(32'h503A113D);
		fork
			forever begin
				@(posedge clock);
				dst_ready <= ($urandom_range(3) != 0);
			end
		join_none
		repeat (3) @(posedge clock);
		wb(0, 8'h2C, 32'h0, 32'hFF);
		wb(0, 8'h3C, 32'h0, 32'hFF);
		wb(0, 8'h20, 32'h0, 32'hFF);
		wb(0, 8'hFC, 32'h0, 32'hFFFFFFFF);
		for (i = 0; i < 16; i++) begin
			r = $urandom;
			v = {i[3:2], r[1:0], i[1:0], r[3:2]};
			wb(1, 8'h2C, {24'h0, v}, 32'h0);
			wb(0, 8'h2C, {24'h0, v & 8'hFC}, 32'hFF);
		end
		wb(1, 8'h3C, 32'hFF, 32'h0);
		wb(0, 8'h3C, 32'h01, 32'hFF);
		req <= 1'b1;
		repeat (4) @(posedge clock);
		wb(0, 8'h20, 32'hF0, 32'hF0);
		req <= 1'b0;
		repeat (4) @(posedge clock);
		wb(0, 8'h20, 32'h00, 32'hF0);
		wb(1, 8'h3C, 32'h0, 32'h0);
		wb(1, 8'h00, 32'h0100, 32'h0);
		wb(1, 8'h10, 32'h4, 32'h0);
		wb(1, 8'h2C, 32'h04, 32'h0);
		beats(1'b1, 16'h0100, 4, 1'b0);
		slow <= 1'b1;
		req <= 1'b1;
		drain();
		req <= 1'b0;
		wb(0, 8'h20, 32'h0F, 32'h0F);
		wb(0, 8'h20, 32'h00, 32'h0F);
		wb(1, 8'h00, 32'h0200, 32'h0);
		wb(1, 8'h10, 32'h6, 32'h0);
		wb(1, 8'h28, 32'h1, 32'h0);
		wb(1, 8'h2C, 32'hB8, 32'h0);
		beats(1'b0, 16'h0200, 3, 1'b1);
		slow <= 1'b0;
		wb(1, 8'h24, $urandom, 32'h0);
		drain();
		wb(0, 8'h00, 32'h0200, 32'hFFFF);
		wb(0, 8'h10, 32'h0006, 32'hFFFF);
		wb(1, 8'h28, 32'h0, 32'h0);
		wb(1, 8'h10, 32'h5, 32'h0);
		wb(1, 8'h2C, 32'h04, 32'h0);
		insert <= 1'b0;
		repeat (6) @(posedge clock);
		wb(0, 8'h3C, 32'h01, 32'hFF);
		insert <= 1'b1;
		req <= 1'b1;
		repeat (20) @(posedge clock);
		wb(0, 8'h10, 32'h0005, 32'hFFFF);
		beats(1'b1, 16'h0200, 5, 1'b0);
		wb(1, 8'h3C, 32'h0, 32'h0);
		drain();
		req <= 1'b0;
		wb(1, 8'h00, 32'h0300, 32'h0);
		wb(1, 8'h10, 32'h3, 32'h0);
		wb(1, 8'h2C, 32'h44, 32'h0);
		wb(1, 8'h20, 32'h04, 32'h0);
		beats(1'b1, 16'h0300, 2, 1'b0);
		// Single mode: one beat per request pulse, none while disabled
		for (int p = 0; p < 3; p++) begin
			req <= 1'b1;
			repeat (12) @(posedge clock);
			req <= 1'b0;
			repeat (6) @(posedge clock);
			if (p == 0) begin
				wb(0, 8'h10, 32'h0003, 32'hFFFF);
				wb(1, 8'h20, 32'h00, 32'h0);
			end
		end
		drain();
		wb(0, 8'h10, 32'h0001, 32'hFFFF);
		wb(1, 8'h3C, 32'h1, 32'h0);
		wb(1, 8'h34, $urandom, 32'h0);
		wb(0, 8'h2C, 32'h0, 32'hFF);
		wb(0, 8'h3C, 32'h0, 32'hFF);
		wb(0, 8'h10, 32'h0, 32'hFFFF);
		wb(0, 8'h00, 32'h0, 32'hFFFF);
		wb(0, 8'h20, 32'h0, 32'hFF);
		repeat (4) @(posedge clock);
		wrap_up();
	end
endmodule // sdd_top_tb_top
`default_nettype wire
